// ==== shared/clock_gen_unit_pkg.sv ====
// Purpose: constants and types shared by the clock generation and reset unit
// Assumes: one 25 MHz system clock; all slower clocks are one-cycle enables
// Notes:   source codes index the group and PLL source selectors
package clock_gen_unit_pkg;
  localparam int NUM_GROUPS = 11;
  localparam int SRC_W      = 3;
  localparam int ACC_W      = 16;

  // base clock source codes (group selectors)
  localparam logic [2:0] SRC_OSC   = 3'h0;
  localparam logic [2:0] SRC_RTC   = 3'h1;
  localparam logic [2:0] SRC_BCK   = 3'h2;
  localparam logic [2:0] SRC_WS    = 3'h3;
  localparam logic [2:0] SRC_CARD  = 3'h4;
  localparam logic [2:0] SRC_LPPLL = 3'h5;
  localparam logic [2:0] SRC_HSPLL = 3'h6;
  localparam logic [2:0] SRC_OFF   = 3'h7;
  // on a PLL selector code 5 means the other PLL
  localparam logic [2:0] PLL_SRC_OTHER = 3'h5;
  localparam logic [2:0] GRP_SEL_RESET = SRC_OSC;

  // PLL field widths
  localparam int LP_MUL_W  = 5;
  localparam int LP_PDIV_W = 2;
  localparam int HS_NDIV_W = 8;
  localparam int HS_MUL_W  = 10;
  localparam int HS_PDIV_W = 4;

  // fractional divider layout: groups 0..2 own one, groups 3..5 own two
  localparam int FD_ONE_LAST   = 2;
  localparam int FD_MULTI_LAST = 5;
  localparam int FD_MULTI_N    = 2;
  localparam int FD_TOTAL      = 9;

  // peripheral bus bridge
  localparam int         PB_GROUP  = 0;
  localparam logic [1:0] PB_CYCLES = 2'h3;

  // reset timing
  localparam int         CLK_PERIOD_NS   = 40;
  localparam int         RST_STRETCH_NS  = 200;
  localparam int         RST_STRETCH_CYC = (RST_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         RST_CNT_W       = 4;
  localparam logic [31:0] RESET_VECTOR   = 32'h0000_0000;

  typedef enum logic [2:0] {
    SW_RUN  = 3'b001,
    SW_STOP = 3'b010,
    SW_WAIT = 3'b100
  } sw_state_t;
endpackage

// ==== hdl/clock_gen_unit.sv ====
// Purpose: clock generation and reset unit: PLLs, group source switching,
//          fractional dividers, per-function gating and chip/block resets
// Assumes: every generated clock is a one-cycle enable on i_clk
// Notes:   external clock pins are treated as slow levels and edge-detected
// How it works
// - chip reset is raised by power-on reset, the reset pin or a watchdog request and by nothing else.
// - on reset release chip reset drops and fetch starts from the reset vector 0; block resets follow one cycle later.
// - a sticky flag records that the last chip reset came from the watchdog.
// - each block has its own software reset output driven from a control bit.
// - each PLL selects osc, rtc, bit clock, word select, card clock or the other PLL.
// - the low-power PLL multiplies by 1 to 32 and divides by 1, 2, 4 or 8.
// - the high-speed PLL divides by 1 to 256, multiplies by 1 to 1024, divides by 1 to 16.
// - eleven groups each select one of several base clock sources.
// - changing a group source never yields a runt or glitch on the group clock.
// - groups 0-2 own one fractional divider, groups 3-5 two, assignable per function.
// - every function has its own clock enable.
// - in auto mode an event signal turns a function clock on and off.
// - a peripheral bus access completes in three peripheral clock ticks.
`timescale 1ns/1ps
module clock_gen_unit
  import clock_gen_unit_pkg::*;
#(
  parameter int FUNCS   = 4,
  parameter int NUM_BLK = 16
) (
  // clock and power-on reset
  input  wire logic                           i_clk,
  input  wire logic                           i_rst_n,
  // external clock and reset pins
  input  wire logic                           i_osc_clk,
  input  wire logic                           i_rtc_clk,
  input  wire logic                           i_bck,
  input  wire logic                           i_ws,
  input  wire logic                           i_card_clk,
  input  wire logic                           i_rst_pin_n,
  // watchdog
  input  wire logic                           i_wdt_rst_req,
  input  wire logic                           i_wdt_flag_clr,
  // low-power PLL
  input  wire logic [SRC_W-1:0]               i_lp_src,
  input  wire logic [LP_MUL_W-1:0]            i_lp_mul,
  input  wire logic [LP_PDIV_W-1:0]           i_lp_pdiv,
  // high-speed PLL
  input  wire logic [SRC_W-1:0]               i_hs_src,
  input  wire logic [HS_NDIV_W-1:0]           i_hs_ndiv,
  input  wire logic [HS_MUL_W-1:0]            i_hs_mul,
  input  wire logic [HS_PDIV_W-1:0]           i_hs_pdiv,
  // groups, dividers, functions
  input  wire logic [NUM_GROUPS*SRC_W-1:0]    i_grp_sel,
  input  wire logic [FD_TOTAL*ACC_W-1:0]      i_fd_num,
  input  wire logic [FD_TOTAL*ACC_W-1:0]      i_fd_den,
  input  wire logic [NUM_GROUPS*FUNCS-1:0]    i_func_en,
  input  wire logic [NUM_GROUPS*FUNCS-1:0]    i_func_auto,
  input  wire logic [NUM_GROUPS*FUNCS-1:0]    i_func_evt,
  input  wire logic [NUM_GROUPS*FUNCS-1:0]    i_func_fd_sel,
  // block software resets
  input  wire logic [NUM_BLK-1:0]             i_sw_rst,
  // peripheral bus bridge
  input  wire logic                           i_pb_req,
  output logic                                o_pb_ready,
  output logic                                o_pb_done,
  // clock enables and group switch status
  output logic                                o_lp_tick,
  output logic                                o_hs_tick,
  output logic [NUM_GROUPS-1:0]               o_grp_tick,
  output logic [NUM_GROUPS-1:0]               o_grp_switching,
  output logic [NUM_GROUPS*FUNCS-1:0]         o_func_tick,
  // resets and status
  output logic                                o_chip_rst_n,
  output logic                                o_fetch_start,
  output logic [31:0]                         o_fetch_addr,
  output logic                                o_wdt_caused,
  output logic [NUM_BLK-1:0]                  o_blk_rst_n
);

  typedef struct packed {
    logic [5:0]                           s1;
    logic [5:0]                           s2;
    logic [5:0]                           s3;
    logic                                 lp_tick;
    logic                                 hs_tick;
    logic [ACC_W-1:0]                     lp_acc;
    logic [ACC_W-1:0]                     hs_acc;
    logic [HS_NDIV_W-1:0]                 hs_pre;
    logic [NUM_GROUPS-1:0][SRC_W-1:0]     cur;
    sw_state_t [NUM_GROUPS-1:0]           st;
    logic [NUM_GROUPS-1:0]                grp_tick;
    logic [FD_TOTAL-1:0][ACC_W-1:0]       fd_acc;
    logic [FD_TOTAL-1:0]                  fd_tick;
    logic [NUM_GROUPS*FUNCS-1:0]          func_tick;
    logic [RST_CNT_W-1:0]                 rst_cnt;
    logic                                 chip_rst;
    logic                                 fetch_start;
    logic                                 wdt_flag;
    logic [NUM_BLK-1:0]                   blk_rst;
    logic [1:0]                           pb_cnt;
    logic                                 pb_busy;
    logic                                 pb_done;
  } state_t;

  state_t s;
  state_t next_s;

  // rate accumulator: adds step per input tick, one output pulse per div reached
  function automatic logic [ACC_W:0] rate_step(input logic [ACC_W-1:0] acc,
                                               input logic             tick,
                                               input logic [ACC_W-1:0] step,
                                               input logic [ACC_W-1:0] div);
    logic [ACC_W:0] sum;
    sum = {1'b0, acc} + (tick ? {1'b0, step} : {(ACC_W+1){1'b0}});
    if (div == {ACC_W{1'b0}}) begin
      return {tick, {ACC_W{1'b0}}};
    end
    if (sum >= {1'b0, div}) begin
      sum = sum - {1'b0, div};
      // saturate the backlog; a fast ratio caps at one pulse per cycle
      if (sum[ACC_W]) begin
        sum = {1'b0, {ACC_W{1'b1}}};
      end
      return {1'b1, sum[ACC_W-1:0]};
    end
    return {1'b0, sum[ACC_W-1:0]};
  endfunction

  function automatic logic pll_in(input logic [SRC_W-1:0] sel,
                                  input logic [4:0]       pins,
                                  input logic             other);
    if (sel == PLL_SRC_OTHER) begin
      return other;
    end else if (sel < PLL_SRC_OTHER) begin
      return pins[sel];
    end
    return 1'b0;
  endfunction

  function automatic int fd_count(input int g);
    if (g <= FD_ONE_LAST) begin
      return 1;
    end else if (g <= FD_MULTI_LAST) begin
      return FD_MULTI_N;
    end
    return 0;
  endfunction

  function automatic int fd_base(input int g);
    if (g <= FD_ONE_LAST) begin
      return g;
    end
    return FD_ONE_LAST + 1 + (g - FD_ONE_LAST - 1) * FD_MULTI_N;
  endfunction

  always_comb begin
    logic [4:0]       pin_tick;
    logic [7:0]       src;
    logic [ACC_W:0]   r;
    logic             lp_in;
    logic             hs_in;
    logic             hs_pre_tick;
    logic [SRC_W-1:0] req;
    logic             base;
    logic             en;
    logic             pin_low;
    logic             chip_req;
    int               b;
    int               n;
    int               i;
    pin_tick    = s.s2[4:0] & ~s.s3[4:0];
    src         = {1'b0, s.hs_tick, s.lp_tick, pin_tick};
    r           = '0;
    lp_in       = 1'b0;
    hs_in       = 1'b0;
    hs_pre_tick = 1'b0;
    req         = '0;
    base        = 1'b0;
    en          = 1'b0;
    pin_low     = ~s.s2[5];
    chip_req    = pin_low | i_wdt_rst_req;
    b           = 0;
    n           = 0;
    i           = 0;
    next_s      = s;

    // pin synchronisers and edge stages
    next_s.s1 = {i_rst_pin_n, i_card_clk, i_ws, i_bck, i_rtc_clk, i_osc_clk};
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;

    // low-power PLL
    lp_in          = pll_in(i_lp_src, pin_tick, s.hs_tick);
    r              = rate_step(s.lp_acc, lp_in,
                               ACC_W'({1'b0, i_lp_mul}) + ACC_W'(1),
                               ACC_W'(1) << i_lp_pdiv);
    next_s.lp_tick = r[ACC_W];
    next_s.lp_acc  = r[ACC_W-1:0];

    // high-speed PLL: pre-divider, then multiply and post-divide
    hs_in = pll_in(i_hs_src, pin_tick, s.lp_tick);
    if (hs_in) begin
      if (s.hs_pre >= i_hs_ndiv) begin
        next_s.hs_pre = '0;
        hs_pre_tick   = 1'b1;
      end else begin
        next_s.hs_pre = s.hs_pre + HS_NDIV_W'(1);
      end
    end
    r              = rate_step(s.hs_acc, hs_pre_tick,
                               ACC_W'({1'b0, i_hs_mul}) + ACC_W'(1),
                               ACC_W'({1'b0, i_hs_pdiv}) + ACC_W'(1));
    next_s.hs_tick = r[ACC_W];
    next_s.hs_acc  = r[ACC_W-1:0];

    for (int g = 0; g < NUM_GROUPS; g++) begin
      req = i_grp_sel[g*SRC_W +: SRC_W];
      // glitch-free source change
      case (s.st[g])
        SW_RUN: begin
          if (req != s.cur[g]) begin
            next_s.st[g] = SW_STOP;
          end
        end
        SW_STOP: begin
          // old clock finishes its period before it is dropped
          if (src[s.cur[g]] || s.cur[g] == SRC_OFF) begin
            next_s.cur[g] = req;
            next_s.st[g]  = SW_WAIT;
          end
        end
        SW_WAIT: begin
          // first new edge only aligns; the next one is passed
          if (src[s.cur[g]] || s.cur[g] == SRC_OFF) begin
            next_s.st[g] = SW_RUN;
          end
        end
        default: begin
          next_s.st[g] = SW_RUN;
        end
      endcase
      next_s.grp_tick[g] = (s.st[g] == SW_RUN) && (req == s.cur[g]) && src[s.cur[g]];

      b = fd_base(g);
      n = fd_count(g);
      for (int k = 0; k < FD_MULTI_N; k++) begin
        if (k < n) begin
          r = rate_step(s.fd_acc[b+k], s.grp_tick[g],
                        i_fd_num[(b+k)*ACC_W +: ACC_W],
                        i_fd_den[(b+k)*ACC_W +: ACC_W]);
          next_s.fd_tick[b+k] = r[ACC_W];
          next_s.fd_acc[b+k]  = r[ACC_W-1:0];
        end
      end

      for (int f = 0; f < FUNCS; f++) begin
        i = g * FUNCS + f;
        if (n == 0) begin
          base = s.grp_tick[g];
        end else if (n == 1) begin
          base = s.fd_tick[b];
        end else begin
          base = s.fd_tick[b + int'(i_func_fd_sel[i])];
        end
        en = i_func_auto[i] ? i_func_evt[i] : i_func_en[i];
        next_s.func_tick[i] = base & en & ~s.chip_rst;
      end
    end

    // chip reset and its stretch
    if (chip_req) begin
      next_s.rst_cnt  = RST_CNT_W'(RST_STRETCH_CYC);
      next_s.chip_rst = 1'b1;
    end else if (s.rst_cnt != '0) begin
      next_s.rst_cnt  = s.rst_cnt - RST_CNT_W'(1);
      next_s.chip_rst = 1'b1;
    end else begin
      next_s.chip_rst = 1'b0;
    end
    next_s.fetch_start = s.chip_rst & ~next_s.chip_rst;

    // watchdog cause flag: set wins over clear
    if (i_wdt_rst_req) begin
      next_s.wdt_flag = 1'b1;
    end else if (pin_low || i_wdt_flag_clr) begin
      next_s.wdt_flag = 1'b0;
    end

    next_s.blk_rst = i_sw_rst | {NUM_BLK{s.chip_rst}};

    // peripheral bus bridge timing
    next_s.pb_done = 1'b0;
    if (!s.pb_busy) begin
      if (i_pb_req && !s.chip_rst) begin
        next_s.pb_busy = 1'b1;
        next_s.pb_cnt  = '0;
      end
    end else if (s.grp_tick[PB_GROUP]) begin
      if (s.pb_cnt == PB_CYCLES - 2'h1) begin
        next_s.pb_busy = 1'b0;
        next_s.pb_done = 1'b1;
      end else begin
        next_s.pb_cnt = s.pb_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s             <= '0;
      s.cur         <= {NUM_GROUPS{GRP_SEL_RESET}};
      for (int g = 0; g < NUM_GROUPS; g++) begin
        s.st[g]     <= SW_RUN;
      end
      s.rst_cnt     <= RST_CNT_W'(RST_STRETCH_CYC);
      s.chip_rst    <= 1'b1;
      s.blk_rst     <= {NUM_BLK{1'b1}};
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      o_grp_switching[g] = (s.st[g] != SW_RUN);
    end
  end

  assign o_pb_ready    = ~s.pb_busy & ~s.chip_rst;
  assign o_pb_done     = s.pb_done;
  assign o_lp_tick     = s.lp_tick;
  assign o_hs_tick     = s.hs_tick;
  assign o_grp_tick    = s.grp_tick;
  assign o_func_tick   = s.func_tick;
  assign o_chip_rst_n  = ~s.chip_rst;
  assign o_fetch_start = s.fetch_start;
  assign o_fetch_addr  = RESET_VECTOR;
  assign o_wdt_caused  = s.wdt_flag;
  assign o_blk_rst_n   = ~s.blk_rst;

endmodule

// ==== sim/clock_pins_model.sv ====
// Purpose: slow external clock pins that feed the clock unit
// Assumes: pins change just after the system clock edge
// Notes:   periods 4, 32, 6, 16 and 10 system cycles
`timescale 1ns/1ps
module clock_pins_model (
  // system clock
  input  wire logic       i_clk,
  // osc, rtc, bit clock, word select, card clock
  output logic      [4:0] o_pins
);
  int cnt = 0;
  always_ff @(posedge i_clk) begin
    cnt <= cnt + 1;
  end
  // five selectable sources
  assign o_pins = {1'((cnt / 5) % 2), cnt[3], 1'((cnt / 3) % 2), cnt[4], cnt[1]};
endmodule

// ==== sim/clock_gen_unit_checker.sv ====
// Purpose: port-level checks of the clock generation and reset unit
// Assumes: o_grp_tick is the peripheral clock that the bridge counts
// Notes:   bound into every clock_gen_unit instance
`timescale 1ns/1ps
module clock_gen_unit_checker
  import clock_gen_unit_pkg::*;
#(
  parameter int FUNCS   = 4,
  parameter int NUM_BLK = 16
) (
  // clock and reset
  input wire logic                        i_clk,
  input wire logic                        i_rst_n,
  // watched inputs
  input wire logic                        i_wdt_rst_req,
  input wire logic                        i_wdt_flag_clr,
  input wire logic [NUM_GROUPS*SRC_W-1:0] i_grp_sel,
  input wire logic [NUM_GROUPS*FUNCS-1:0] i_func_en,
  input wire logic [NUM_GROUPS*FUNCS-1:0] i_func_auto,
  input wire logic [NUM_GROUPS*FUNCS-1:0] i_func_evt,
  input wire logic [NUM_BLK-1:0]          i_sw_rst,
  input wire logic                        i_pb_req,
  // watched outputs
  input wire logic                        o_pb_ready,
  input wire logic                        o_pb_done,
  input wire logic [NUM_GROUPS-1:0]       o_grp_tick,
  input wire logic [NUM_GROUPS-1:0]       o_grp_switching,
  input wire logic [NUM_GROUPS*FUNCS-1:0] o_func_tick,
  input wire logic                        o_chip_rst_n,
  input wire logic                        o_fetch_start,
  input wire logic [31:0]                 o_fetch_addr,
  input wire logic                        o_wdt_caused,
  input wire logic [NUM_BLK-1:0]          o_blk_rst_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [3:0]                  pb_cnt;
  logic [NUM_GROUPS*FUNCS-1:0] want;
  assign want = (i_func_auto & i_func_evt) | (~i_func_auto & i_func_en);
  // bridge ticks seen since the transfer was taken
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pb_cnt <= 4'h0;
    end else if (i_pb_req && o_pb_ready) begin
      pb_cnt <= 4'h0;
    end else if (o_grp_tick[PB_GROUP] && pb_cnt != 4'hf) begin
      pb_cnt <= pb_cnt + 4'h1;
    end
  end
  AST_FETCH_ON_RELEASE: assert property ($rose(o_chip_rst_n) |-> o_fetch_start)
    else $error("no fetch start at reset release");
  AST_FETCH_ONCE: assert property (o_fetch_start |-> $rose(o_chip_rst_n) ##1 !o_fetch_start)
    else $error("fetch start outside reset release");
  AST_FETCH_VECTOR: assert property (o_fetch_addr == 32'h0000_0000)
    else $error("fetch address not zero");
  AST_WDT_RESETS: assert property (i_wdt_rst_req |-> ##[1:2] !o_chip_rst_n)
    else $error("watchdog request gave no chip reset");
  AST_WDT_FLAG_SET: assert property (i_wdt_rst_req |=> o_wdt_caused)
    else $error("watchdog cause not recorded");
  AST_WDT_FLAG_CLR: assert property (i_wdt_flag_clr && !i_wdt_rst_req |=> !o_wdt_caused)
    else $error("watchdog cause not cleared");
  AST_BLK_RST: assert property (o_blk_rst_n ==
    ~($past(i_sw_rst) | {NUM_BLK{~$past(o_chip_rst_n)}}))
    else $error("block reset mismatch");
  AST_PB_BUSY: assert property (i_pb_req && o_pb_ready |=> !o_pb_ready)
    else $error("bridge ready while busy");
  AST_PB_THREE: assert property (o_pb_done |-> pb_cnt == {2'b00, PB_CYCLES})
    else $error("bridge access not three peripheral ticks");
  AST_GRP_QUIET: assert property ((o_grp_tick & o_grp_switching) == '0)
    else $error("group tick during source switch");
  AST_SW_TAKE: assert property ($changed(i_grp_sel[6*SRC_W+:SRC_W]) && !o_grp_switching[6]
    |=> o_grp_switching[6])
    else $error("source change not taken");
  AST_FUNC_GATE: assert property ((o_func_tick & ~$past(want)) == '0)
    else $error("function tick while disabled");
  cover property (o_pb_done);
  cover property ($rose(o_chip_rst_n));
  cover property ($rose(o_grp_switching[6]));
  cover property ($rose(o_wdt_caused));
endmodule
bind clock_gen_unit clock_gen_unit_checker #(.FUNCS(FUNCS), .NUM_BLK(NUM_BLK)) i_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wdt_rst_req(i_wdt_rst_req),
  .i_wdt_flag_clr(i_wdt_flag_clr), .i_grp_sel(i_grp_sel), .i_func_en(i_func_en),
  .i_func_auto(i_func_auto), .i_func_evt(i_func_evt), .i_sw_rst(i_sw_rst),
  .i_pb_req(i_pb_req), .o_pb_ready(o_pb_ready), .o_pb_done(o_pb_done),
  .o_grp_tick(o_grp_tick), .o_grp_switching(o_grp_switching), .o_func_tick(o_func_tick),
  .o_chip_rst_n(o_chip_rst_n), .o_fetch_start(o_fetch_start), .o_fetch_addr(o_fetch_addr),
  .o_wdt_caused(o_wdt_caused), .o_blk_rst_n(o_blk_rst_n));

// ==== sim/testbench.sv ====
// Purpose: self-checking bench of the clock generation and reset unit
// Assumes: pins come from clock_pins_model; counts over 480 cycles
// Notes:   480 cycles hold a whole number of every source period
`timescale 1ns/1ps
module testbench;
  import clock_gen_unit_pkg::*;
  localparam int NF = NUM_GROUPS * 4;
  typedef struct packed {
    logic [2:0] grp; logic [2:0] lps; logic [4:0] lpm; logic [1:0] lpd;
    logic [2:0] hss; logic [7:0] hsn; logic [9:0] hsm; logic [3:0] hsd; logic [15:0] exp;
  } row_t;
  row_t rows [11] = '{'{0,0,0,0,0,0,0,0,120}, '{1,0,0,0,0,0,0,0,15}, '{2,0,0,0,0,0,0,0,80},
    '{3,0,0,0,0,0,0,0,30}, '{4,0,0,0,0,0,0,0,48}, '{7,0,0,0,0,0,0,0,0},
    '{5,1,31,3,0,0,0,0,60}, '{6,0,0,0,3,1,3,1,30}, '{5,4,4,2,0,0,0,0,60},
    '{6,0,0,0,5,3,15,15,30}, '{5,5,1,3,0,0,0,0,30}};
  logic i_clk = 0, i_rst_n = 0, i_rst_pin_n = 0, i_wdt_rst_req = 0, i_wdt_flag_clr = 0;
  logic i_pb_req = 0, o_pb_ready, o_pb_done, o_chip_rst_n, o_fetch_start, o_wdt_caused;
  logic o_lp_tick, o_hs_tick;
  logic [4:0]   pins;
  logic [2:0]   i_lp_src = 0, i_hs_src = 0;
  logic [4:0]   i_lp_mul = 0;
  logic [1:0]   i_lp_pdiv = 0;
  logic [7:0]   i_hs_ndiv = 0;
  logic [9:0]   i_hs_mul = 0;
  logic [3:0]   i_hs_pdiv = 0;
  logic [32:0]  i_grp_sel = 33'h0_001c_0000; // group 6 starts off so row 0 switches
  logic [143:0] i_fd_num = 0, i_fd_den = 0;
  logic [43:0]  i_func_en = 44'hffff_dffffff, i_func_auto = 44'h0000_c000000;
  logic [43:0]  i_func_evt = 44'h0000_4000000, i_func_fd_sel = 44'h0000000_2000, o_func_tick;
  logic [15:0]  i_sw_rst = 0, o_blk_rst_n;
  logic [10:0]  o_grp_tick, o_grp_switching;
  logic [31:0]  o_fetch_addr;
  int fail_count = 0, n_checks = 0, cnt [NF+3];
  clock_pins_model i_pins (.i_clk(i_clk), .o_pins(pins));
  clock_gen_unit i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_osc_clk(pins[0]),
    .i_rtc_clk(pins[1]), .i_bck(pins[2]), .i_ws(pins[3]), .i_card_clk(pins[4]),
    .i_rst_pin_n(i_rst_pin_n), .i_wdt_rst_req(i_wdt_rst_req), .i_wdt_flag_clr(i_wdt_flag_clr),
    .i_lp_src(i_lp_src), .i_lp_mul(i_lp_mul), .i_lp_pdiv(i_lp_pdiv), .i_hs_src(i_hs_src),
    .i_hs_ndiv(i_hs_ndiv), .i_hs_mul(i_hs_mul), .i_hs_pdiv(i_hs_pdiv), .i_grp_sel(i_grp_sel),
    .i_fd_num(i_fd_num), .i_fd_den(i_fd_den), .i_func_en(i_func_en), .i_func_auto(i_func_auto),
    .i_func_evt(i_func_evt), .i_func_fd_sel(i_func_fd_sel), .i_sw_rst(i_sw_rst),
    .i_pb_req(i_pb_req), .o_pb_ready(o_pb_ready), .o_pb_done(o_pb_done),
    .o_lp_tick(o_lp_tick), .o_hs_tick(o_hs_tick), .o_grp_tick(o_grp_tick),
    .o_grp_switching(o_grp_switching),
    .o_func_tick(o_func_tick), .o_chip_rst_n(o_chip_rst_n), .o_fetch_start(o_fetch_start),
    .o_fetch_addr(o_fetch_addr), .o_wdt_caused(o_wdt_caused), .o_blk_rst_n(o_blk_rst_n));
  always #20 i_clk = ~i_clk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, want);
    end
  endtask
  // 0 chip reset released, 1 group 6 settled, 2 bridge done
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
      if (n > 400) begin
        fail_count++;
        $display("Error at %0t: wait expired", $time);
        print_verdict();
      end
    end while (!(sel == 0 ? o_chip_rst_n === 1'b1 :
                 sel == 1 ? o_grp_switching[6] === 1'b0 : o_pb_done === 1'b1));
  endtask
  task automatic count_win();
    for (int k = 0; k < NF + 3; k++) cnt[k] = 0;
    repeat (480) begin
      @(negedge i_clk);
      for (int k = 0; k < NF; k++) cnt[k] += int'(o_func_tick[k]);
      cnt[NF] += int'(o_grp_tick[6]);
      cnt[NF+1] += int'(o_lp_tick);
      cnt[NF+2] += int'(o_hs_tick);
    end
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    @(negedge i_clk);
    check(o_chip_rst_n, 0);
    check(o_blk_rst_n, 0);
    check(o_pb_ready, 0);
    check(o_wdt_caused, 0);
    @(posedge i_clk) i_rst_n <= 1'b1;
    repeat (25000) @(posedge i_clk);
    check(o_chip_rst_n, 0);
    i_rst_pin_n <= 1'b1;
    wait_for(0);
    check(o_fetch_start, 1);
    check(o_fetch_addr, 0);
    $display("reset test done");
    foreach (rows[r]) begin
      @(posedge i_clk);
      i_grp_sel[18+:3] <= rows[r].grp;
      {i_lp_src, i_lp_mul, i_lp_pdiv} <= {rows[r].lps, rows[r].lpm, rows[r].lpd};
      {i_hs_src, i_hs_ndiv, i_hs_mul, i_hs_pdiv} <=
        {rows[r].hss, rows[r].hsn, rows[r].hsm, rows[r].hsd};
      @(posedge i_clk);
      @(negedge i_clk);
      check(o_grp_switching[6], 1);
      wait_for(1);
      repeat (100) @(negedge i_clk);
      count_win();
      check(cnt[NF], rows[r].exp);
      check(cnt[rows[r].grp == 3'h5 ? NF + 1 : rows[r].grp == 3'h6 ? NF + 2 : NF], rows[r].exp);
      check(cnt[24], rows[r].exp);
      check(cnt[25], 0);
      check(cnt[26], rows[r].exp);
      check(cnt[27], 0);
    end
    $display("source table done");
    @(posedge i_clk);
    i_fd_num <= {9{16'h0001}};
    i_fd_den <= {64'h0, 16'h0004, 16'h0002, 32'h0, 16'h0004};
    repeat (100) @(negedge i_clk);
    count_win();
    check(cnt[0], 30);
    check(cnt[4], 120);
    check(cnt[12], 60);
    check(cnt[13], 30);
    $display("divider test done");
    @(posedge i_clk) i_pb_req <= 1'b1;
    wait_for(2);
    wait_for(2);
    @(posedge i_clk) i_pb_req <= 1'b0;
    wait_for(2);
    @(negedge i_clk);
    check(o_pb_ready, 1);
    $display("bridge test done");
    @(posedge i_clk) i_wdt_rst_req <= 1'b1;
    @(posedge i_clk) i_wdt_rst_req <= 1'b0;
    @(negedge i_clk);
    check(o_chip_rst_n, 0);
    check(o_wdt_caused, 1);
    wait_for(0);
    check(o_fetch_start, 1);
    check(o_wdt_caused, 1);
    @(posedge i_clk) i_wdt_flag_clr <= 1'b1;
    @(posedge i_clk) i_wdt_flag_clr <= 1'b0;
    @(negedge i_clk);
    check(o_wdt_caused, 0);
    $display("watchdog test done");
    @(posedge i_clk) i_sw_rst <= 16'h00a5;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    check(o_blk_rst_n, 16'hff5a);
    @(posedge i_clk) i_rst_n <= 1'b0;
    @(negedge i_clk);
    check(o_chip_rst_n, 0);
    check(o_blk_rst_n, 0);
    @(posedge i_clk) i_rst_n <= 1'b1;
    wait_for(0);
    check(o_fetch_start, 1);
    $display("block reset test done");
    print_verdict();
  end
endmodule
